//--- core/dpsc_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Shared constants for the potentiometer serial control port
// ----------------------------------------------------------------
package dpsc_pkg;
	// Core clock
	localparam int CLK_PERIOD_NS = 40;                 // 25 MHz core clock

	// Serial word layout
	localparam int WORD_W  = 16;                       // Bits per frame word
	localparam int CNT_W   = 4;                        // Bit counter, modulo one word
	localparam int CMD_MSB = 13;                       // Command field top bit
	localparam int CMD_LSB = 10;                       // Command field bottom bit
	localparam int CMD_W   = 4;                        // Command field width
	localparam int DATA_W  = 10;                       // Data field width, bits 9..0
	localparam int POS_BITS_DEF = 10;                  // Default wiper resolution
	localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;      // Sixteenth bit of a word
	localparam logic [CNT_W-1:0] CNT_TOP  = 4'hF;      // Index of the first bit out

	// Command codes
	localparam logic [CMD_W-1:0] CMD_NOP     = 4'h0;   // No operation
	localparam logic [CMD_W-1:0] CMD_WR_WIPR = 4'h1;   // Write wiper register
	localparam logic [CMD_W-1:0] CMD_RD_WIPR = 4'h2;   // Read wiper register
	localparam logic [CMD_W-1:0] CMD_STORE   = 4'h3;   // Store wiper into otp memory
	localparam logic [CMD_W-1:0] CMD_RESTORE = 4'h4;   // Software restore from otp

	// Wiper values
	localparam logic [DATA_W-1:0] MIDSCALE  = 10'h200; // Unprogrammed restore value
	localparam logic [DATA_W-1:0] WIPER_RST = 10'h200; // Value after core reset

	// One-time-programmable wiper memory
	localparam int OTP_DEPTH = 20;                     // Program opportunities
	localparam int OTP_IDX_W = 5;                      // Index and count width

	// Execution times, in their own units
	localparam int T_WR_NS      = 410;                 // Longest wiper write
	localparam int T_RD_NS      = 450;                 // Longest wiper readback
	localparam int T_NOP_NS     = 410;                 // Other commands
	localparam int T_STORE_MS   = 6;                   // Otp store, about
	localparam int T_RESTORE_US = 1500;                // Least restore time

	// Execution times in core cycles
	localparam int EXEC_W      = 18;                   // Execution counter width
	localparam int WR_CYC      = T_WR_NS / CLK_PERIOD_NS;
	localparam int RD_CYC      = T_RD_NS / CLK_PERIOD_NS;
	localparam int NOP_CYC     = T_NOP_NS / CLK_PERIOD_NS;
	localparam int STORE_CYC   = (T_STORE_MS * 1000000) / CLK_PERIOD_NS;
	localparam int RESTORE_CYC = (T_RESTORE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Command execution states
	typedef enum logic {
		ST_IDLE,
		ST_EXEC
	} dpsc_state_t;
endpackage
`default_nettype wire

//--- core/dpsc_otp_mem.sv
`default_nettype none
// ----------------------------------------------------------------
// One-time-programmable wiper memory
// ----------------------------------------------------------------
// Entries fill upward; a restore always reads the last one written.
module dpsc_otp_mem #(
	parameter int DEPTH = dpsc_pkg::OTP_DEPTH,
	parameter int WIDTH = dpsc_pkg::DATA_W,
	parameter int IDX_W = dpsc_pkg::OTP_IDX_W
) (
	input  wire logic             mclk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	input  wire logic             wr_en_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic      [WIDTH-1:0] rd_data_o,
	output logic      [IDX_W-1:0] used_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];   // Storage, no reset needed
	logic [IDX_W-1:0] used_ff;         // Entries programmed so far
	logic [WIDTH-1:0] rd_data_ff;      // Registered last entry
	logic             room;            // A free entry remains

	assign room = (used_ff < IDX_W'(DEPTH));

	// ----------------------------------------------------------------
	// Write port
	// ----------------------------------------------------------------
	// Writes past the last entry are dropped, as on a spent part
	always_ff @(posedge mclk_i)
	begin
		if (ce_i && wr_en_i && room)
		begin
			mem_q[used_ff] <= wr_data_i;
		end
	end

	// Count of programmed entries
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			used_ff <= '0;
		else if (ce_i && wr_en_i && room)
			used_ff <= used_ff + IDX_W'(1);
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Continuously presents the newest entry, zero while empty
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rd_data_ff <= '0;
		else if (ce_i)
			rd_data_ff <= (used_ff == '0) ? '0 : mem_q[used_ff - IDX_W'(1)];
	end

	assign rd_data_o = rd_data_ff;
	assign used_o    = used_ff;
endmodule
`default_nettype wire

//--- core/dpsc_port.sv
`default_nettype none
// Function
// R1: Reset pin reloads wiper from otp memory
// R2: Empty otp memory restores midscale instead
// R3: Reset acts on rising edge only
// R4: Sixteen-bit shift register, captured on clock fall
// R5: Host keeps serial clock at most 50 MHz
// R6: Frame-sync low enables shifting
// R7: Frame-sync rise after sixteen bits updates register
// R8: Early frame-sync rise aborts, nothing changes
// R9: Open-drain serial output shows shift data
// R10: Open-drain ready marks operation completion
// R11: Word is MSB first: 00, command, data
// R12: Only whole multiples of sixteen bits accepted
// R13: Low resolution ignores two lowest data bits
// R14: Otp store locks shift register, ready marks end
// R15: Ready driven low while a command executes
module dpsc_port #(
	parameter int POS_BITS    = dpsc_pkg::POS_BITS_DEF,
	parameter int STORE_CYC   = dpsc_pkg::STORE_CYC,
	parameter int RESTORE_CYC = dpsc_pkg::RESTORE_CYC
) (
	input  wire logic                        mclk_i,
	input  wire logic                        rstn_i,
	input  wire logic                        ce_i,
	input  wire logic                        hw_reset_i,
	input  wire logic                        sclk_i,
	input  wire logic                        sync_n_i,
	input  wire logic                        din_i,
	input  wire logic                        serial_data_out_i,
	output logic                             serial_data_out_o,
	output logic                             serial_data_out_oe_n_o,
	input  wire logic                        ready_i,
	output logic                             ready_o,
	output logic                             ready_oe_n_o,
	output logic [dpsc_pkg::DATA_W-1:0]      wiper_register_o
);
	// ----------------------------------------------------------------
	// Local constants
	// ----------------------------------------------------------------
	localparam int DW = dpsc_pkg::DATA_W;
	localparam int EW = dpsc_pkg::EXEC_W;
	// Write latency seen by checks: count runs out, then the wiper edge follows
	localparam int WR_CYC_A = dpsc_pkg::WR_CYC + 1;
	// Low data bits dropped in the lower resolution variant
	localparam logic [DW-1:0] POS_MASK = ~(DW'((1 << (DW - POS_BITS)) - 1));

	// ----------------------------------------------------------------
	// Link side state, on the serial clock
	// ----------------------------------------------------------------
	logic [dpsc_pkg::WORD_W-1:0] shift_ff;        // Input shift register
	logic [dpsc_pkg::CNT_W-1:0]  bit_cnt_ff;      // Bits taken, modulo a word
	logic                        full_ff;         // At least one word taken
	logic                        fresh_ff;        // No bit yet in this frame
	logic                        frm_tog_ff;      // Flips on the first bit of each frame
	logic                        lock_meta_ff;    // Store lock, first stage
	logic                        lock_ff;         // Store lock, usable
	logic                        rb_meta_ff;      // Readback toggle, first stage
	logic                        rb_sync_ff;      // Readback toggle, usable
	logic                        rb_seen_ff;      // Readback toggle already served
	logic                        rb_mode;         // Current frame shifts readback
	logic [dpsc_pkg::CNT_W-1:0]  out_idx;         // Readback bit now leaving
	logic                        sdo_oe_n_ff;     // Low drives the data pin low
	logic                        sdo_ff;          // Open-drain level, always low

	// ----------------------------------------------------------------
	// Core side state
	// ----------------------------------------------------------------
	logic                        sync_meta_ff;    // Frame-sync, first stage
	logic                        sync_ff;         // Frame-sync, usable
	logic                        sync_d_ff;       // Frame-sync, one cycle later
	logic                        hwr_meta_ff;     // Reset pin, first stage
	logic                        hwr_ff;          // Reset pin, usable
	logic                        hwr_d_ff;        // Reset pin, one cycle later
	logic                        frm_seen_ff;     // Frame toggle at the last close
	logic                        frame_rise;      // Frame just closed
	logic                        hwr_rise;        // Reset pin just went high
	logic                        frame_ok;        // Frame held whole words
	logic [dpsc_pkg::CMD_W-1:0]  word_cmd;        // Command of the closed frame
	logic [DW-1:0]               word_data;       // Data of the closed frame
	dpsc_pkg::dpsc_state_t       state_ff;        // Command execution state
	logic [EW-1:0]               exec_cnt_ff;     // Cycles left in execution
	logic [dpsc_pkg::CMD_W-1:0]  op_ff;           // Command being executed
	logic [DW-1:0]               op_data_ff;      // Its data field
	logic                        launch;          // A command starts now
	logic                        finish;          // The command ends now
	logic [DW-1:0]               wiper_ff;        // Wiper register
	logic [dpsc_pkg::WORD_W-1:0] rb_word_ff;      // Word for the next frame out
	logic                        rb_tog_ff;       // Flips when readback is ready
	logic                        store_ff;        // Store lock level toward link side
	logic                        rdy_oe_n_ff;     // Low drives ready low
	logic                        rdy_ff;          // Open-drain level, always low
	logic                        otp_wr;          // Program one otp entry
	logic [DW-1:0]               otp_rd_data;     // Newest otp entry
	logic [dpsc_pkg::OTP_IDX_W-1:0] otp_used;     // Entries programmed

	// ----------------------------------------------------------------
	// Frame start marker
	// ----------------------------------------------------------------
	// Set straight by a high frame-sync, since the serial clock may be still
	always_ff @(negedge sclk_i or posedge sync_n_i or negedge rstn_i)
	begin
		if (!rstn_i)
			fresh_ff <= 1'b1;
		else if (sync_n_i)
			fresh_ff <= 1'b1;
		else
			fresh_ff <= 1'b0;
	end

	// Store lock carried into the serial clock domain
	always_ff @(negedge sclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lock_meta_ff <= 1'b0;
			lock_ff      <= 1'b0;
		end
		else
		begin
			lock_meta_ff <= store_ff;
			lock_ff      <= lock_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Shift register and bit counter
	// ----------------------------------------------------------------
	// Contents hold after the frame so the core can read them at leisure
	always_ff @(negedge sclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			shift_ff   <= '0;
			bit_cnt_ff <= '0;
			full_ff    <= 1'b0;
			rb_seen_ff <= 1'b0;
			frm_tog_ff <= 1'b0;
		end
		else if (!sync_n_i && !lock_ff)                            // [R6] [R14]
		begin
			shift_ff <= {shift_ff[dpsc_pkg::WORD_W-2:0], din_i};  // [R4] [R11]
			if (fresh_ff)
			begin
				bit_cnt_ff <= dpsc_pkg::CNT_W'(1);
				full_ff    <= 1'b0;
				frm_tog_ff <= ~frm_tog_ff;
			end
			else
			begin
				bit_cnt_ff <= bit_cnt_ff + dpsc_pkg::CNT_W'(1);
				full_ff    <= full_ff | (bit_cnt_ff == dpsc_pkg::CNT_LAST);
				// Readback word fully sent on the sixteenth bit
				if (bit_cnt_ff == dpsc_pkg::CNT_LAST)
					rb_seen_ff <= rb_sync_ff;
			end
		end
	end

	// Readback toggle into the serial clock domain
	always_ff @(posedge sclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rb_meta_ff <= 1'b0;
			rb_sync_ff <= 1'b0;
		end
		else
		begin
			rb_meta_ff <= rb_tog_ff;
			rb_sync_ff <= rb_meta_ff;
		end
	end

	// The toggle lands on the second rising edge and drives from the third; the first two bits out are the
	// previous word's top two bits, which are always zero, so nothing is lost
	assign rb_mode = (rb_sync_ff != rb_seen_ff);
	assign out_idx = fresh_ff ? dpsc_pkg::CNT_TOP : (dpsc_pkg::CNT_TOP - bit_cnt_ff);

	// ----------------------------------------------------------------
	// Serial data output, open-drain
	// ----------------------------------------------------------------
	always_ff @(posedge sclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sdo_oe_n_ff <= 1'b1;
			sdo_ff      <= 1'b0;
		end
		else if (rb_mode)
			sdo_oe_n_ff <= rb_word_ff[out_idx];                      // [R9]
		else
			sdo_oe_n_ff <= shift_ff[dpsc_pkg::WORD_W-1];             // [R9]
	end

	// ----------------------------------------------------------------
	// Synchronisers for frame-sync and reset pin
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync_meta_ff <= 1'b1;
			sync_ff      <= 1'b1;
			sync_d_ff    <= 1'b1;
			hwr_meta_ff  <= 1'b1;
			hwr_ff       <= 1'b1;
			hwr_d_ff     <= 1'b1;
		end
		else if (ce_i)
		begin
			sync_meta_ff <= sync_n_i;
			sync_ff      <= sync_meta_ff;
			sync_d_ff    <= sync_ff;
			hwr_meta_ff  <= hw_reset_i;
			hwr_ff       <= hwr_meta_ff;
			hwr_d_ff     <= hwr_ff;
		end
	end

	// Frame toggle noted at every close; an empty frame cannot replay the last word
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			frm_seen_ff <= 1'b0;
		else if (ce_i && frame_rise)
			frm_seen_ff <= frm_tog_ff;                               // [R8]
	end

	assign frame_rise = sync_ff & ~sync_d_ff;                        // [R7]
	assign hwr_rise   = hwr_ff & ~hwr_d_ff;                          // [R3]
	// Link state is quiet once frame-sync is high, so it is read directly
	assign frame_ok   = full_ff && (bit_cnt_ff == '0)
		&& (frm_tog_ff != frm_seen_ff);                              // [R8] [R12]
	assign word_cmd   = shift_ff[dpsc_pkg::CMD_MSB:dpsc_pkg::CMD_LSB];
	assign word_data  = shift_ff[DW-1:0];
	assign launch     = (state_ff == dpsc_pkg::ST_IDLE) && frame_rise && frame_ok;
	assign finish     = (state_ff == dpsc_pkg::ST_EXEC) && (exec_cnt_ff == EW'(1)) && !hwr_rise;
	assign otp_wr     = finish && (op_ff == dpsc_pkg::CMD_STORE);

	// Execution time for each command
	function automatic logic [EW-1:0] exec_len(input logic [dpsc_pkg::CMD_W-1:0] cmd);
		case (cmd)
			dpsc_pkg::CMD_WR_WIPR: exec_len = EW'(dpsc_pkg::WR_CYC);
			dpsc_pkg::CMD_RD_WIPR: exec_len = EW'(dpsc_pkg::RD_CYC);
			dpsc_pkg::CMD_STORE:   exec_len = EW'(STORE_CYC);
			dpsc_pkg::CMD_RESTORE: exec_len = EW'(RESTORE_CYC);
			default:               exec_len = EW'(dpsc_pkg::NOP_CYC);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Command execution state machine
	// ----------------------------------------------------------------
	// Frames closing while busy are dropped; a reset pin rise always wins
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_ff    <= dpsc_pkg::ST_IDLE;
			exec_cnt_ff <= '0;
			op_ff       <= dpsc_pkg::CMD_NOP;
			op_data_ff  <= '0;
		end
		else if (ce_i)
		begin
			if (hwr_rise)                                            // [R3]
			begin
				state_ff    <= dpsc_pkg::ST_EXEC;
				op_ff       <= dpsc_pkg::CMD_RESTORE;
				exec_cnt_ff <= EW'(RESTORE_CYC);
			end
			else
			begin
				case (state_ff)
					dpsc_pkg::ST_IDLE:
					begin
						// Short or ragged frames fall through untouched
						if (launch)                                  // [R7] [R8]
						begin
							state_ff    <= dpsc_pkg::ST_EXEC;
							op_ff       <= word_cmd;
							op_data_ff  <= word_data;
							exec_cnt_ff <= exec_len(word_cmd);
						end
					end
					dpsc_pkg::ST_EXEC:
					begin
						if (exec_cnt_ff == EW'(1))
							state_ff <= dpsc_pkg::ST_IDLE;
						else
							exec_cnt_ff <= exec_cnt_ff - EW'(1);
					end
					default:
						state_ff <= dpsc_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Wiper register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wiper_ff <= dpsc_pkg::WIPER_RST;
		else if (ce_i && finish)
		begin
			if (op_ff == dpsc_pkg::CMD_WR_WIPR)
				wiper_ff <= op_data_ff & POS_MASK;                   // [R7] [R13]
			else if (op_ff == dpsc_pkg::CMD_RESTORE)
			begin
				if (otp_used == '0)
					wiper_ff <= dpsc_pkg::MIDSCALE;                  // [R2]
				else
					wiper_ff <= otp_rd_data & POS_MASK;              // [R1]
			end
		end
	end

	// ----------------------------------------------------------------
	// Readback word and its toggle
	// ----------------------------------------------------------------
	// Word and toggle change on the same edge; the toggle's two-stage sync lets the link read the word stable
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rb_word_ff <= '0;
			rb_tog_ff  <= 1'b0;
		end
		else if (ce_i && finish && (op_ff == dpsc_pkg::CMD_RD_WIPR))
		begin
			rb_word_ff <= {{(dpsc_pkg::WORD_W - DW){1'b0}}, wiper_ff};
			rb_tog_ff  <= ~rb_tog_ff;
		end
	end

	// Store lock level for the link side
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			store_ff <= 1'b0;
		else if (ce_i)
			store_ff <= (state_ff == dpsc_pkg::ST_EXEC) && (op_ff == dpsc_pkg::CMD_STORE)
				&& !finish;                                          // [R14]
	end

	// ----------------------------------------------------------------
	// Ready output, open-drain, high means done
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rdy_oe_n_ff <= 1'b1;
			rdy_ff      <= 1'b0;
		end
		else if (ce_i)
		begin
			if (hwr_rise || launch)
				rdy_oe_n_ff <= 1'b0;                                 // [R15]
			else if (finish)
				rdy_oe_n_ff <= 1'b1;                                 // [R10] [R14]
		end
	end

	dpsc_otp_mem u_otp (
		.mclk_i    (mclk_i),
		.rstn_i    (rstn_i),
		.ce_i      (ce_i),
		.wr_en_i   (otp_wr),
		.wr_data_i (wiper_ff),
		.rd_data_o (otp_rd_data),
		.used_o    (otp_used)
	);

	assign serial_data_out_o      = sdo_ff;
	assign serial_data_out_oe_n_o = sdo_oe_n_ff;
	assign ready_o                = rdy_ff;
	assign ready_oe_n_o           = rdy_oe_n_ff;
	assign wiper_register_o       = wiper_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_launch_write;
		(state_ff == dpsc_pkg::ST_IDLE) && frame_rise && frame_ok && !hwr_rise
			&& (word_cmd == dpsc_pkg::CMD_WR_WIPR);
	endsequence

	sequence s_restore_end;
		(state_ff == dpsc_pkg::ST_EXEC) && (op_ff == dpsc_pkg::CMD_RESTORE)
			&& (exec_cnt_ff == EW'(1)) && !hwr_rise;
	endsequence

	property p_write_lands;
		@(posedge mclk_i) disable iff (!rstn_i || !ce_i)
		s_launch_write |-> ##WR_CYC_A (wiper_ff == $past(word_data & POS_MASK, WR_CYC_A));
	endproperty

	a_write_lands: assert property (p_write_lands) // [R7]
		else $error("wiper not updated after full frame");
	a_abort_ignored: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R8]
		(state_ff == dpsc_pkg::ST_IDLE) && frame_rise && !frame_ok && !hwr_rise
			|=> $stable(wiper_ff) && (state_ff == dpsc_pkg::ST_IDLE))
		else $error("partial frame changed state");
	a_reset_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R3]
		hwr_rise |=> (state_ff == dpsc_pkg::ST_EXEC) && (op_ff == dpsc_pkg::CMD_RESTORE)
			&& !rdy_oe_n_ff)
		else $error("reset pin rise did not start restore");
	a_restore_mid: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R2]
		s_restore_end and (otp_used == '0) |=> (wiper_ff == dpsc_pkg::MIDSCALE))
		else $error("empty otp restore not midscale");
	a_restore_otp: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R1]
		s_restore_end and (otp_used != '0) |=> (wiper_ff == ($past(otp_rd_data) & POS_MASK)))
		else $error("restore did not load otp value");
	a_ready_busy: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R15]
		launch && !hwr_rise |=> !rdy_oe_n_ff [*2])
		else $error("ready not driven low on launch");
	a_ready_done: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R10]
		finish |=> rdy_oe_n_ff && (state_ff == dpsc_pkg::ST_IDLE))
		else $error("ready not released on completion");
	a_store_lock: assert property (@(posedge mclk_i) disable iff (!rstn_i || !ce_i) // [R14]
		(state_ff == dpsc_pkg::ST_EXEC) && (op_ff == dpsc_pkg::CMD_STORE) && !finish
			|=> store_ff && $stable(wiper_ff))
		else $error("store not locked");
	a_low_bits: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [R13]
		(wiper_ff & ~POS_MASK) == '0 || $past(!rstn_i))
		else $error("dropped wiper bits not zero");
	a_shift_take: assert property (@(negedge sclk_i) disable iff (!rstn_i) // [R4]
		!sync_n_i && !lock_ff |=> (shift_ff[0] == $past(din_i)))
		else $error("shift register missed a bit");
	a_sdo_shift: assert property (@(posedge sclk_i) disable iff (!rstn_i) // [R9]
		!rb_mode |=> (sdo_oe_n_ff == $past(shift_ff[dpsc_pkg::WORD_W-1])))
		else $error("serial output not shift msb");
endmodule
`default_nettype wire

//--- test/dpsc_host.sv
`default_nettype none
// ----------------------------------------------------------------
// Serial host model, link clock runs only inside frames
// ----------------------------------------------------------------
module dpsc_host (
	output logic      sclk_o,
	output logic      sync_n_o,
	output logic      din_o,
	input  wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] rx; // Bits seen on the data out line
	initial
	begin
		sclk_o = 1'b0;
		sync_n_o = 1'b1;
		din_o = 1'b0;
		rx = 32'h0;
	end
	// 48 ns clock, data moves on the rise, MSB first
	task automatic send(input logic [31:0] w, input int n);
		sync_n_o = 1'b0; // Frame opens
		for (int i = n - 1; i >= 0; i--)
		begin
			#24 sclk_o = 1'b1;
			din_o = w[i];
			#24 sclk_o = 1'b0;
			rx = {rx[30:0], sdo_i};
		end
		#24 sync_n_o = 1'b1;
		din_o = ~din_o; // Released line must not echo the last bit
	endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i, rstn_i, hw, sclk, sync_n, din, sdo_l, sdo_oe_n, rdy_l, rdy_oe_n;
	wire logic serial_data_out = sdo_oe_n ? 1'b1 : sdo_l; // Pull-up resolves the pin
	wire logic rdy = rdy_oe_n ? 1'b1 : rdy_l;
	logic [9:0] wip, v, u;
	int n_mismatch, check_count, seed;
	initial
	begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	dpsc_port #(.POS_BITS(10), .STORE_CYC(40), .RESTORE_CYC(30)) u_dut (.mclk_i(mclk_i),
		.rstn_i(rstn_i), .ce_i(1'b1), .hw_reset_i(hw), .sclk_i(sclk), .sync_n_i(sync_n),
		.din_i(din), .serial_data_out_i(serial_data_out), .serial_data_out_o(sdo_l),
		.serial_data_out_oe_n_o(sdo_oe_n), .ready_i(rdy), .ready_o(rdy_l),
		.ready_oe_n_o(rdy_oe_n), .wiper_register_o(wip));
	dpsc_host u_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din), .sdo_i(serial_data_out));
	// Frame word to send: 00, command, data
	function automatic logic [15:0] wr(input logic [3:0] c, input logic [9:0] d);
		return {2'b00, c, d};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// Ready low then high again, or never low when refused
	task automatic wait_rdy(input bit busy);
		bit seen;
		int k;
		seen = 0;
		for (k = 0; k < 100 && !(seen && rdy === 1'b1); k++)
		begin
			@(negedge mclk_i);
			if (rdy === 1'b0)
				seen = 1;
			if (!busy && k > 20)
				break;
		end
		if (k == 100)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t ready timeout", $time);
			results();
		end
		chk(seen == busy, "ready pulse");
		repeat (11) @(negedge mclk_i); // Frame-sync high gap
	endtask
	task automatic xfer(input logic [31:0] w, input int n, input bit busy);
		u_host.send(w, n);
		wait_rdy(busy);
	endtask
	initial
	begin
		seed = 22;
		rstn_i = 1'b0;
		hw = 1'b1;
		repeat (8) @(negedge mclk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		chk(wip === dpsc_pkg::WIPER_RST, "reset value");
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($random(seed));
			xfer(wr(dpsc_pkg::CMD_WR_WIPR, v), 16, 1);
			chk(wip === v, "write");
		end
		u = 10'($random(seed));
		xfer({wr(dpsc_pkg::CMD_WR_WIPR, ~u), wr(dpsc_pkg::CMD_WR_WIPR, u)}, 32, 1);
		chk(wip === u, "two-word frame");
		xfer(32'h0, 0, 0);
		chk(wip === u, "empty frame");
		xfer(wr(dpsc_pkg::CMD_WR_WIPR, ~u), 10, 0);
		chk(wip === u, "abort");
		xfer({16'h0, wr(dpsc_pkg::CMD_WR_WIPR, ~u)}, 17, 0);
		chk(wip === u, "odd length");
		xfer(wr(dpsc_pkg::CMD_RD_WIPR, 10'h0), 16, 1);
		xfer(wr(dpsc_pkg::CMD_NOP, 10'h0), 16, 1);
		chk(u_host.rx[15:0] === {6'h00, u}, "readback");
		hw = 1'b0;
		repeat (10) @(negedge mclk_i);
		chk(wip === u, "reset pin low");
		hw = 1'b1;
		wait_rdy(1);
		chk(wip === dpsc_pkg::MIDSCALE, "empty restore");
		xfer(wr(dpsc_pkg::CMD_WR_WIPR, u), 16, 1);
		xfer(wr(dpsc_pkg::CMD_STORE, 10'h0), 16, 1);
		xfer(wr(dpsc_pkg::CMD_WR_WIPR, ~u), 16, 1);
		xfer(wr(dpsc_pkg::CMD_RESTORE, 10'h0), 16, 1);
		chk(wip === u, "soft restore");
		xfer(wr(dpsc_pkg::CMD_WR_WIPR, ~u), 16, 1);
		hw = 1'b0;
		repeat (3) @(negedge mclk_i);
		hw = 1'b1;
		wait_rdy(1);
		chk(wip === u, "pin restore");
		results();
	end
endmodule
`default_nettype wire
